// File: pkg/apf_cfg.svh
/*
  Constants of the command frame parser: framing bytes, offsets, command
  names and parameter reset values. Assumes inclusion by bare name.
*/
`ifndef APF_CFG_SVH
`define APF_CFG_SVH
`define APF_START       8'h7e
`define APF_ESC         8'h7d
`define APF_ESC_XOR     8'h20
`define APF_CSUM_GOOD   8'hff
`define APF_TYPE_NOW    8'h08
`define APF_TYPE_QUEUE  8'h09
`define APF_HDR_LEN     16'h0004
`define APF_MAX_VAL     16'h0008
`define APF_CMD_JOIN    16'h4e4a
`define APF_CMD_RATE    16'h4244
`define APF_CMD_APPLY   16'h4143
`define APF_CMD_MODE    16'h4150
`define APF_JOIN_RST    32'h000000ff
`define APF_RATE_RST    32'h00000003
`define APF_MODE_RST    32'h00000001
`define APF_MODE_ESC    32'h00000002
`define APF_ST_OK       8'h00
`define APF_ST_ERROR    8'h01
`define APF_ST_BADCMD   8'h02
`define APF_ST_BADSUM   8'h03
`define APF_ST_BADLEN   8'h04
`endif

// File: pkg/apf_pkg.sv
/*
  Types of the command frame parser.
  Assumes apf_cfg.svh holds the numeric constants.
*/
package apf_pkg;
  typedef enum logic [3:0] {
    APF_HUNT  = 4'h0,
    APF_LENH  = 4'h1,
    APF_LENL  = 4'h2,
    APF_TYPE  = 4'h3,
    APF_ID    = 4'h4,
    APF_CMDH  = 4'h5,
    APF_CMDL  = 4'h6,
    APF_VAL   = 4'h7,
    APF_SUM   = 4'h8,
    APF_EXEC  = 4'h9,
    APF_RESP  = 4'ha,
    APF_SKIP  = 4'hb
  } apf_state_t;
endpackage

// File: logic/apf_unescape.sv
/*
  Removes escape pairs from the received byte stream when escaping is on.
  Assumes bytes arrive synchronous to mclk with a one-cycle valid.
*/
`timescale 1ns/1ps
`include "apf_cfg.svh"
module apf_unescape
  import apf_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // Mode
  input  wire logic       esc_en,
  // Raw stream
  input  wire logic       in_valid,
  input  wire logic [7:0] in_byte,
  // Clean stream
  output logic            out_valid,
  output logic [7:0]      out_byte,
  output logic            out_start
);
  logic pending;

  // A start marker restarts framing in every parser state but APF_EXEC and APF_RESP, even after a dangling escape.
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      pending <= 1'b0;
    else if (in_valid)
      pending <= esc_en && in_byte == `APF_ESC && in_byte != `APF_START;

  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      out_valid <= 1'b0;
      out_byte  <= 8'h00;
      out_start <= 1'b0;
    end
    else
    begin
      out_start <= in_valid && in_byte == `APF_START;
      out_valid <= in_valid && in_byte != `APF_START
                   && !(esc_en && in_byte == `APF_ESC);
      out_byte  <= pending ? (in_byte ^ `APF_ESC_XOR) : in_byte;
    end
endmodule

// File: logic/apf_buf2.sv
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock; a push while full is refused through in_ready.
*/
`timescale 1ns/1ps
module apf_buf2
  import apf_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             nrst,
  // Fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  logic [WIDTH-1:0] mem [2];
  logic             wp;
  logic             rp;
  logic [1:0]       cnt;
  logic             push;
  logic             pop;

  assign push      = in_valid && cnt != 2'd2;
  assign pop       = out_ready && cnt != 2'd0;
  assign in_ready  = cnt != 2'd2;
  assign out_valid = cnt != 2'd0;
  assign out_data  = mem[rp];

  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      wp  <= 1'b0;
      rp  <= 1'b0;
      cnt <= 2'd0;
    end
    else
    begin
      wp  <= wp ^ push;
      rp  <= rp ^ pop;
      cnt <= cnt + {1'b0, push} - {1'b0, pop};
    end

  always_ff @(posedge mclk)
    if (push)
      mem[wp] <= in_data;
endmodule

// File: logic/apf_parser.sv
/*
  Command frame parser: frames serial bytes, checks length and checksum,
  executes set, query and queue commands on three parameters, and emits a
  response record (frame id, status, command, value) through a buffer.
  Assumes a byte receiver with a one-cycle valid strobe, and a response
  formatter that drains rsp_* with rsp_ready.
*/
`timescale 1ns/1ps
`include "apf_cfg.svh"
// Operation
// - Drop bytes until start marker seen
// - Two length bytes, high byte first
// - Checksum byte makes body sum 0xff
// - Report bad frame or checksum status
// - Type 0x08 executes then applies pending
// - Frame id echoed; zero means silence
// - Two command characters choose the parameter
// - Value bytes write; none means query
// - Type 0x09 only queues new values
// - Queued-type query answers at once
// - Active setting stays until apply
// - One, two, four byte values equal
// - Multi-byte values arrive high byte first
// - Escapes removed before checksum
module apf_parser
  import apf_pkg::*;
#(
  parameter int VAL_BYTES = 4
)
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // Received serial bytes
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_byte,
  // Response records
  output logic             rsp_valid,
  output logic [7:0]       rsp_frame_id,
  output logic [7:0]       rsp_status,
  output logic [15:0]      rsp_cmd,
  output logic [31:0]      rsp_value,
  input  wire logic        rsp_ready,
  // Active parameters
  output logic [31:0]      join_permit_time_param,
  output logic [31:0]      serial_rate_param,
  output logic [31:0]      api_framing_mode_param,
  // Back-pressure to the byte receiver
  output logic             rx_stall
);
  // ==========================================================
  // Unescaping
  logic        cl_valid;
  logic [7:0]  cl_byte;
  logic        cl_start;

  apf_unescape u_unesc (
    .mclk      (mclk),
    .nrst      (nrst),
    .esc_en    (api_framing_mode_param == `APF_MODE_ESC),
    .in_valid  (rx_valid),
    .in_byte   (rx_byte),
    .out_valid (cl_valid),
    .out_byte  (cl_byte),
    .out_start (cl_start)
  );

  // ==========================================================
  // Frame state
  apf_state_t  state;
  logic [15:0] len;
  logic [15:0] left;
  logic [7:0]  sum;
  logic [7:0]  ftype;
  logic [7:0]  fid;
  logic [15:0] cmd;
  logic [31:0] val;
  logic [3:0]  nval;
  logic [7:0]  status;
  logic        b_ready;

  logic [31:0] pend_join;
  logic [31:0] pend_rate;
  logic [31:0] pend_mode;
  logic [31:0] cur;
  logic        known;

  always_comb
  begin
    known = 1'b1;
    cur   = 32'h0;
    unique case (cmd)
      `APF_CMD_JOIN: cur = join_permit_time_param;
      `APF_CMD_RATE: cur = serial_rate_param;
      `APF_CMD_MODE: cur = api_framing_mode_param;
      `APF_CMD_APPLY: cur = 32'h0;
      default:       known = 1'b0;
    endcase
  end

  // ==========================================================
  // Byte walker
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      state  <= APF_HUNT;
      len    <= 16'h0;
      left   <= 16'h0;
      sum    <= 8'h0;
      ftype  <= 8'h0;
      fid    <= 8'h0;
      cmd    <= 16'h0;
      val    <= 32'h0;
      nval   <= 4'h0;
      status <= `APF_ST_OK;
    end
    else if (cl_start && state != APF_EXEC && state != APF_RESP)
    begin
      state <= APF_LENH;
      sum   <= 8'h0;
      nval  <= 4'h0;
      val   <= 32'h0;
    end
    else
    begin
      unique case (state)
        APF_HUNT, APF_SKIP:
          state <= state;
        APF_LENH:
          if (cl_valid)
          begin
            len[15:8] <= cl_byte;
            state     <= APF_LENL;
          end
        APF_LENL:
          if (cl_valid)
          begin
            len[7:0] <= cl_byte;
            left     <= {len[15:8], cl_byte};
            state    <= APF_TYPE;
          end
        APF_TYPE, APF_ID, APF_CMDH, APF_CMDL, APF_VAL:
          if (cl_valid)
          begin
            sum  <= sum + cl_byte;
            left <= left - 16'h1;
            unique case (state)
              APF_TYPE: ftype     <= cl_byte;
              APF_ID:   fid       <= cl_byte;
              APF_CMDH: cmd[15:8] <= cl_byte;
              APF_CMDL: cmd[7:0]  <= cl_byte;
              default:
              begin
                val  <= {val[23:0], cl_byte};
                nval <= nval + 4'h1;
              end
            endcase
            if (left == 16'h1)
              state <= APF_SUM;
            else if (state != APF_VAL)
              state <= apf_state_t'(state + 4'h1);
          end
        APF_SUM:
          if (cl_valid)
          begin
            state <= APF_EXEC;
            if (sum + cl_byte != `APF_CSUM_GOOD)
              status <= `APF_ST_BADSUM;
            else if (len < `APF_HDR_LEN || nval > 4'(VAL_BYTES))
              status <= `APF_ST_BADLEN;
            else if (!known)
              status <= `APF_ST_BADCMD;
            else
              status <= `APF_ST_OK;
          end
        APF_EXEC:
          if (status != `APF_ST_OK && status != `APF_ST_BADLEN
              && status != `APF_ST_BADSUM && status != `APF_ST_BADCMD)
            state <= APF_HUNT;
          else if (ftype != `APF_TYPE_NOW && ftype != `APF_TYPE_QUEUE
                   && status != `APF_ST_BADSUM)
            state <= APF_HUNT;
          else
            state <= (fid == 8'h00) ? APF_HUNT : APF_RESP;
        APF_RESP:
          if (b_ready)
            state <= APF_HUNT;
        default:
          state <= APF_HUNT;
      endcase
    end

  // ==========================================================
  // Parameter store: pending copies and active copies
  logic executing;
  logic writing;
  logic applying;

  assign executing = state == APF_EXEC && status == `APF_ST_OK;
  assign writing   = executing && nval != 4'h0 && cmd != `APF_CMD_APPLY;
  assign applying  = executing
                     && (ftype == `APF_TYPE_NOW
                         || ftype == `APF_TYPE_QUEUE && cmd == `APF_CMD_APPLY);

  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      pend_join <= `APF_JOIN_RST;
      pend_rate <= `APF_RATE_RST;
      pend_mode <= `APF_MODE_RST;
    end
    else if (writing && (ftype == `APF_TYPE_NOW
                         || ftype == `APF_TYPE_QUEUE))
    begin
      if (cmd == `APF_CMD_JOIN)
        pend_join <= val;
      if (cmd == `APF_CMD_RATE)
        pend_rate <= val;
      if (cmd == `APF_CMD_MODE)
        pend_mode <= val;
    end

  // The apply uses the value being written in this same frame.
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      join_permit_time_param <= `APF_JOIN_RST;
      serial_rate_param      <= `APF_RATE_RST;
      api_framing_mode_param <= `APF_MODE_RST;
    end
    else if (applying)
    begin
      join_permit_time_param <= (writing && cmd == `APF_CMD_JOIN)
                                ? val : pend_join;
      serial_rate_param      <= (writing && cmd == `APF_CMD_RATE)
                                ? val : pend_rate;
      api_framing_mode_param <= (writing && cmd == `APF_CMD_MODE)
                                ? val : pend_mode;
    end

  // ==========================================================
  // Response path
  logic [63:0] rec;
  logic        b_valid;
  logic [63:0] b_data;

  // A query returns the active value at once, for either frame type.
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      rec <= 64'h0;
    else if (state == APF_EXEC)
      rec <= {fid, status, cmd, (nval == 4'h0 && status == `APF_ST_OK)
              ? cur : 32'h0};

  apf_buf2 #(.WIDTH(64)) u_buf (
    .mclk      (mclk),
    .nrst      (nrst),
    .in_valid  (state == APF_RESP),
    .in_data   (rec),
    .in_ready  (b_ready),
    .out_valid (b_valid),
    .out_data  (b_data),
    .out_ready (!rsp_valid)
  );

  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      rsp_valid    <= 1'b0;
      rsp_frame_id <= 8'h0;
      rsp_status   <= 8'h0;
      rsp_cmd      <= 16'h0;
      rsp_value    <= 32'h0;
    end
    else if (rsp_valid)
      rsp_valid <= !rsp_ready;
    else if (b_valid)
    begin
      rsp_valid <= 1'b1;
      {rsp_frame_id, rsp_status, rsp_cmd, rsp_value} <= b_data;
    end

  // Stalls the receiver while a frame's outcome is being posted.
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      rx_stall <= 1'b0;
    else
      rx_stall <= state == APF_EXEC || state == APF_RESP || !b_ready;
endmodule

// File: testbench/apf_parser_checker.sv
/* Checker of the command frame parser's ports.
   Assumes a bind onto apf_parser and a single clock domain. */
`timescale 1ns/1ps
`include "apf_cfg.svh"
module apf_parser_checker
#(
  parameter int VAL_BYTES = 4
)
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // Byte stream
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_stall,
  // Response records
  input  wire logic        rsp_valid,
  input  wire logic [7:0]  rsp_frame_id,
  input  wire logic [7:0]  rsp_status,
  input  wire logic [15:0] rsp_cmd,
  input  wire logic [31:0] rsp_value,
  input  wire logic        rsp_ready,
  // Active parameters
  input  wire logic [31:0] join_permit_time_param,
  input  wire logic [31:0] serial_rate_param,
  input  wire logic [31:0] api_framing_mode_param
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // ====
  // Outcomes must follow a received byte closely, so count idle cycles.
  logic [7:0] idle;
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      idle <= 8'h00;
    else if (rx_valid)
      idle <= 8'h00;
    else if (idle != 8'hff)
      idle <= idle + 8'h01;
  a_rsp_hold:
    assert property (rsp_valid && !rsp_ready |=> rsp_valid
      && $stable(rsp_frame_id)) else $error("record id moved");
  a_cmd_hold:
    assert property (rsp_valid && !rsp_ready |=> $stable(rsp_cmd)
      && $stable(rsp_value)) else $error("record body moved");
  a_id_nonzero:
    assert property (rsp_valid |-> rsp_frame_id != 8'h00)
      else $error("record for silent frame");
  a_status_known:
    assert property (rsp_valid |-> rsp_status inside {8'h00, 8'h02,
      8'h03, 8'h04}) else $error("unknown status");
  a_err_value:
    assert property (rsp_valid && rsp_status != 8'h00 |-> rsp_value == 0)
      else $error("failed record carries value");
  a_param_cause:
    assert property ($changed({join_permit_time_param, serial_rate_param,
      api_framing_mode_param}) |-> idle < 8'd12)
      else $error("parameter moved without a frame");
  a_rsp_cause:
    assert property ($rose(rsp_valid) |-> idle < 8'd16)
      else $error("record without a frame");
  a_reset_params:
    assert property ($rose(nrst) |-> serial_rate_param == `APF_RATE_RST
      && join_permit_time_param == `APF_JOIN_RST)
      else $error("bad reset parameters");
endmodule
bind apf_parser apf_parser_checker #(.VAL_BYTES(VAL_BYTES)) i_chk (
  .mclk(mclk), .nrst(nrst), .rx_valid(rx_valid), .rx_byte(rx_byte),
  .rx_stall(rx_stall), .rsp_valid(rsp_valid), .rsp_frame_id(rsp_frame_id),
  .rsp_status(rsp_status), .rsp_cmd(rsp_cmd), .rsp_value(rsp_value),
  .rsp_ready(rsp_ready), .join_permit_time_param(join_permit_time_param),
  .serial_rate_param(serial_rate_param),
  .api_framing_mode_param(api_framing_mode_param));

// File: testbench/apf_host_model.sv
/* Host model: frames command bodies and sends them byte by byte.
   Assumes calls start just after a clock edge. */
`timescale 1ns/1ps
module apf_host_model
(
  // Clock
  input  wire logic       mclk,
  // Byte stream
  output logic            rx_valid,
  output logic [7:0]      rx_byte,
  input  wire logic       rx_stall
);
  initial
  begin
    rx_valid = 1'b0;
    rx_byte  = 8'h00;
  end
  // The idle line shows the inverse, so a stale byte is never reused.
  task automatic put(input logic [7:0] b);
    int n;
    n = 0;
    while (rx_stall && n < 100)
    begin
      @(posedge mclk) #1;
      n++;
    end
    if (n == 100)
    begin
      apf_parser_tb_top.chk("rx_stall", rx_stall, 1'b0);
      apf_parser_tb_top.close_out();
    end
    rx_valid = 1'b1;
    rx_byte  = b;
    @(posedge mclk) #1;
    rx_valid = 1'b0;
    rx_byte  = ~b;
    @(posedge mclk) #1;
  endtask
  task automatic put_x(input logic [7:0] b, input logic esc);
    if (esc && b inside {8'h7e, 8'h7d, 8'h11, 8'h13})
    begin
      put(8'h7d);
      put(b ^ 8'h20);
    end
    else
      put(b);
  endtask
  task automatic send(input logic [7:0] body[$], input logic esc,
                      input logic [7:0] bad);
    logic [7:0]  sum;
    logic [15:0] len;
    sum = 8'h00;
    len = 16'(body.size());
    put(8'h7e);
    put_x(len[15:8], esc);
    put_x(len[7:0], esc);
    foreach (body[i])
    begin
      put_x(body[i], esc);
      sum = sum + body[i];
    end
    put_x((8'hff - sum) ^ bad, esc);
  endtask
endmodule

// File: testbench/apf_parser_tb_top.sv
/* Bench of the command frame parser: a table of command frames, then
   garbage, silent, unknown-type and escaped cases.
   Assumes the host model and the bound checker. */
`timescale 1ns/1ps
`include "apf_cfg.svh"
module apf_parser_tb_top;
  typedef struct {
    logic [7:0]  typ;
    logic [7:0]  id;
    logic [15:0] cmd;
    int          n;
    logic [39:0] val;
    logic [7:0]  st;
    logic [31:0] rv;
    logic [31:0] jn;
    logic [31:0] rt;
  } apf_row_t;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic        rsp_ready = 1'b0;
  logic        rx_valid, rx_stall, rsp_valid;
  logic [7:0]  rx_byte, rsp_frame_id, rsp_status;
  logic [15:0] rsp_cmd;
  logic [31:0] rsp_value, jn_p, rt_p, md_p;
  logic [7:0]  q[$];
  int          error_cnt = 0;
  int          samples_checked = 0;
  apf_row_t rows[9] = '{
    '{8'h08, 8'h01, 16'h4e4a, 1, 40'h20, 8'h00, 0, 32'h20, 32'h3},
    '{8'h08, 8'h02, 16'h4e4a, 0, 40'h0, 8'h00, 32'h20, 32'h20, 32'h3},
    '{8'h09, 8'h03, 16'h4244, 2, 40'h7, 8'h00, 0, 32'h20, 32'h3},
    '{8'h09, 8'h04, 16'h4244, 0, 40'h0, 8'h00, 32'h3, 32'h20, 32'h3},
    '{8'h09, 8'h05, 16'h4143, 0, 40'h0, 8'h00, 0, 32'h20, 32'h7},
    '{8'h09, 8'h06, 16'h4e4a, 4, 40'h30, 8'h00, 0, 32'h20, 32'h7},
    '{8'h08, 8'h07, 16'h4244, 4, 40'h5, 8'h00, 0, 32'h30, 32'h5},
    '{8'h08, 8'h08, 16'h5a5a, 0, 40'h0, 8'h02, 0, 32'h30, 32'h5},
    '{8'h08, 8'h09, 16'h4e4a, 5, 40'h1, 8'h04, 0, 32'h30, 32'h5}};
  always #2.5 mclk = ~mclk;
  apf_host_model i_host (.mclk(mclk), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .rx_stall(rx_stall));
  apf_parser #(.VAL_BYTES(4)) i_dut (.mclk(mclk), .nrst(nrst),
    .rx_valid(rx_valid), .rx_byte(rx_byte), .rsp_valid(rsp_valid),
    .rsp_frame_id(rsp_frame_id), .rsp_status(rsp_status),
    .rsp_cmd(rsp_cmd), .rsp_value(rsp_value), .rsp_ready(rsp_ready),
    .join_permit_time_param(jn_p), .serial_rate_param(rt_p),
    .api_framing_mode_param(md_p), .rx_stall(rx_stall));
  // ====
  // Shared tasks
  task automatic chk(input string nm, input logic [39:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic step(input int c);
    repeat (c) @(posedge mclk) #1;
  endtask
  // The record is left standing a few cycles to prove it is held.
  task automatic resp(input logic [7:0] id, st, input logic [31:0] v,
                      input logic [15:0] c);
    int n;
    n = 0;
    while (rsp_valid !== 1'b1)
    begin
      if (n++ == 200)
      begin
        chk("rsp_valid", 1'b0, 1'b1);
        close_out();
      end
      step(1);
    end
    step(3);
    chk("id", rsp_frame_id, id);
    chk("status", rsp_status, st);
    chk("value", rsp_value, v);
    chk("cmd", rsp_cmd, c);
    chk("stall", rx_stall, 1'b0);
    rsp_ready = 1'b1;
    step(1);
    rsp_ready = 1'b0;
  endtask
  task automatic quiet;
    repeat (60)
    begin
      step(1);
      chk("silent", rsp_valid, 1'b0);
    end
  endtask
  initial
  begin
    step(4);
    nrst = 1'b1;
    chk("join", jn_p, `APF_JOIN_RST);
    chk("rate", rt_p, `APF_RATE_RST);
    chk("mode", md_p, `APF_MODE_RST);
    chk("rsp_valid", rsp_valid, 1'b0);
    $display("reset done");
    foreach (rows[i])
    begin
      q = {rows[i].typ, rows[i].id, rows[i].cmd[15:8], rows[i].cmd[7:0]};
      for (int k = rows[i].n - 1; k >= 0; k--)
        q.push_back(rows[i].val[8*k +: 8]);
      i_host.send(q, 1'b0, 8'h00);
      resp(rows[i].id, rows[i].st, rows[i].rv, rows[i].cmd);
      chk("join", jn_p, rows[i].jn);
      chk("rate", rt_p, rows[i].rt);
      $display("row %0d done", i);
    end
    i_host.put(8'h55);
    i_host.put(8'h13);
    q = {8'h08, 8'h0a, 8'h4e, 8'h4a};
    i_host.send(q, 1'b0, 8'h01);
    resp(8'h0a, 8'h03, 0, 16'h4e4a);
    q = {8'h08, 8'h00, 8'h4e, 8'h4a, 8'h44};
    i_host.send(q, 1'b0, 8'h00);
    quiet();
    chk("join", jn_p, 32'h44);
    q = {8'h10, 8'h0b, 8'h4e, 8'h4a, 8'h99};
    i_host.send(q, 1'b0, 8'h00);
    quiet();
    chk("join", jn_p, 32'h44);
    $display("garbage, silent and unknown type done");
    q = {8'h08, 8'h0c, 8'h41, 8'h50, 8'h02};
    i_host.send(q, 1'b0, 8'h00);
    resp(8'h0c, 8'h00, 0, 16'h4150);
    chk("mode", md_p, `APF_MODE_ESC);
    q = {8'h08, 8'h7d, 8'h4e, 8'h4a, 8'h7e};
    i_host.send(q, 1'b1, 8'h00);
    resp(8'h7d, 8'h00, 0, 16'h4e4a);
    chk("join", jn_p, 32'h7e);
    $display("escaped frame done");
    close_out();
  end
endmodule
